/* File: logic/clpf_top.sv */
// character lcd refresh: rams, address counter, scan and blink
//
// Summary of operation
// - 4-line 5-dot lines at 00,20,40,60H
// - extension select streams further cells out
// - address set loads the address counter
// - each data access steps counter by one
// - address counter readable on address read
// - cursor on, cursor blink, cell inversion
// - 34 common and 60 segment outputs
// - bits shift into 60-bit latch, then transfer
// - 1-line mode scans 17 commons
// - 2/4-line mode scans 33 commons
// - rom gives 240 glyphs of 5x8
// - 8 user glyphs replace rom glyphs
// - codes 00-0FH pick user glyph rows
// - 5-dot user rows blink all or P4
// - 6-dot user rows blink all or P5
// - no icon or user dot blinks while blink enable low
// - icon ram drives the icon common
// - icon byte: two blink bits, six pattern
// - icon bytes map five or six icons
// - icon blink all or leftmost bit
// - function set with extension loads enable
// - font width and four-line select bits
`timescale 1ns/100ps
module clpf_top #(
    parameter int EXT_SEGS = clpf_pkg::CLPF_EXT_SEGS,
    parameter int BLINK_FRAMES = clpf_pkg::CLPF_BLINK_FRAMES
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic extension_driver_select_i,
    output logic [clpf_pkg::CLPF_COM_N-1:0] com_o,
    output logic [clpf_pkg::CLPF_SEG_N-1:0] seg_o,
    output logic ext_data_o,
    output logic ext_clk_o,
    output logic ext_latch_o
);
    import clpf_pkg::*;

    localparam int TOTAL = CLPF_SEG_N + EXT_SEGS;

    // bus side state
    logic wr_pend_r; // write data phase in progress
    logic rd_pend_r; // read wait cycle in progress
    logic [7:0] ofs_r; // offset of the current data phase
    logic [31:0] hrdata_r;
    logic hready_r;
    logic [31:0] rd_val; // read mux
    // configuration
    logic [11:0] ctrl_r;
    logic two_line_r; // 2-line when not four-line
    logic be_r; // blink_enable_bit
    logic [6:0] ac_r; // address_counter
    clpf_tgt_t tgt_r; // ram the counter points into
    logic [6:0] ac_mask; // wrap mask of the target
    logic [6:0] ac_step; // counter after one step
    // the three rams
    logic [7:0] cc_ram [128]; // char_code_ram
    logic [7:0] ug_ram [64]; // user_glyph_ram
    logic [7:0] ic_ram [16]; // icon_ram
    // per-line shift offsets
    logic [6:0] off_r [4];
    // pin synchroniser for extension_driver_select
    logic ext_m_r;
    logic ext_s_r;
    // refresh sequencer
    clpf_state_t st_r;
    logic [5:0] scan_r; // common index, 0 is icon common
    logic [6:0] bit_r; // segment bit within the line
    logic [2:0] col_r; // column within the cell
    logic [4:0] pos_r; // cell position
    logic [5:0] frame_r;
    logic phase_r; // blink phase, high = dots off
    logic [CLPF_SEG_N-1:0] seg_sh_r; // segment shift latch
    logic [CLPF_SEG_N-1:0] seg_r;
    logic [CLPF_COM_N-1:0] com_r;
    logic ext_d_r;
    logic ext_c_r;
    logic ext_l_r;

    // decoded mode bits
    logic fw6;
    logic nw4;
    logic multi;
    logic [2:0] wlast; // last column of a cell
    logic [6:0] len; // line length
    logic [6:0] total_w; // bits in this line
    logic [6:0] last_bit;
    logic [5:0] last_com;
    assign fw6 = ctrl_r[CLPF_CTRL_FW];
    assign nw4 = ctrl_r[CLPF_CTRL_NW];
    assign multi = nw4 | two_line_r;
    assign wlast = fw6 ? 3'h5 : 3'h4;
    assign len = nw4 ? CLPF_LEN_4L : (two_line_r ? CLPF_LEN_2L : CLPF_LEN_1L);
    assign total_w = ext_s_r ? 7'(TOTAL) : 7'(CLPF_SEG_N);
    assign last_bit = total_w - 7'h01;
    assign last_com = multi ? CLPF_LAST_ML : CLPF_LAST_1L;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    // ---------------- bus slave ----------------
    logic accept;
    logic wr_do;
    logic rd_do;
    assign accept = hsel_i & htrans_i[1] & hready_i;
    assign wr_do = wr_pend_r;
    assign rd_do = rd_pend_r;

    // reads get one wait cycle so earlier writes have landed
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            ofs_r <= 8'h00;
            hready_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
        end else if (ce_i) begin
            wr_pend_r <= accept & hwrite_i;
            rd_pend_r <= accept & ~hwrite_i;
            hready_r <= ~(accept & ~hwrite_i);
            if (accept) begin
                ofs_r <= haddr_i[7:0];
            end
            if (rd_do) begin
                hrdata_r <= rd_val;
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        case (ofs_r)
            CLPF_OFS_CTRL: rd_val = {20'h0, ctrl_r};
            CLPF_OFS_FUNC: rd_val = {30'h0, be_r, two_line_r};
            CLPF_OFS_ADDR: rd_val = {22'h0, tgt_r, 1'b0, ac_r};
            CLPF_OFS_DATA: begin
                case (tgt_r)
                    CLPF_TGT_USER: rd_val = {24'h0, ug_ram[ac_r[5:0]]};
                    CLPF_TGT_ICON: rd_val = {24'h0, ic_ram[ac_r[3:0]]};
                    default: rd_val = {24'h0, cc_ram[ac_r]};
                endcase
            end
            CLPF_OFS_STAT: rd_val = {23'h0, ext_s_r, phase_r, 1'b0, scan_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // control and function set registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= CLPF_CTRL_RST;
            two_line_r <= 1'b0;
            be_r <= 1'b0;
        end else if (ce_i && wr_do) begin
            if (ofs_r == CLPF_OFS_CTRL) begin
                ctrl_r <= hwdata_i[11:0];
            end
            if (ofs_r == CLPF_OFS_FUNC) begin
                two_line_r <= hwdata_i[CLPF_FUNC_N];
                // enable only moves with the extension bit
                if (hwdata_i[CLPF_FUNC_EXT]) begin
                    be_r <= hwdata_i[CLPF_FUNC_BE];
                end
            end
        end
    end

    // address counter wraps inside the target ram
    always_comb begin
        case (tgt_r)
            CLPF_TGT_USER: ac_mask = CLPF_MASK_USER;
            CLPF_TGT_ICON: ac_mask = CLPF_MASK_ICON;
            default: ac_mask = CLPF_MASK_CHAR;
        endcase
        ac_step = ctrl_r[CLPF_CTRL_INC] ? ac_r + 7'h01 : ac_r - 7'h01;
        ac_step = ac_step & ac_mask;
    end

    // address counter: set by address write, stepped by data access
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ac_r <= 7'h00;
            tgt_r <= CLPF_TGT_CHAR;
        end else if (ce_i) begin
            if (wr_do && ofs_r == CLPF_OFS_ADDR) begin
                tgt_r <= clpf_tgt_t'(hwdata_i[CLPF_ADDR_TGT+:2]);
                case (hwdata_i[CLPF_ADDR_TGT+:2])
                    2'h1: ac_r <= hwdata_i[6:0] & CLPF_MASK_USER;
                    2'h2: ac_r <= hwdata_i[6:0] & CLPF_MASK_ICON;
                    default: ac_r <= hwdata_i[6:0];
                endcase
            end else if ((wr_do | rd_do) && ofs_r == CLPF_OFS_DATA) begin
                ac_r <= ac_step;
            end
        end
    end

    // ram writes at the counter; no reset, contents are data
    always_ff @(posedge clock_i) begin
        if (ce_i && wr_do && ofs_r == CLPF_OFS_DATA) begin
            case (tgt_r)
                CLPF_TGT_USER: ug_ram[ac_r[5:0]] <= hwdata_i[7:0];
                CLPF_TGT_ICON: ic_ram[ac_r[3:0]] <= hwdata_i[7:0];
                default: cc_ram[ac_r] <= hwdata_i[7:0];
            endcase
        end
    end

    // per-line rotation; offsets assume the mode is not changed
    // while lines are shifted
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_line
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    off_r[gi] <= 7'h00;
                end else if (ce_i && wr_do && ofs_r == CLPF_OFS_SHIFT &&
                             hwdata_i[CLPF_SHIFT_GO] &&
                             ctrl_r[CLPF_CTRL_SEN+gi]) begin
                    if (hwdata_i[CLPF_SHIFT_RIGHT]) begin
                        // last address comes to the front
                        off_r[gi] <= (off_r[gi] == 7'h00) ?
                            len - 7'h01 : off_r[gi] - 7'h01;
                    end else begin
                        off_r[gi] <= (off_r[gi] + 7'h01 >= len) ?
                            7'h00 : off_r[gi] + 7'h01;
                    end
                end
            end
        end
    endgenerate

    // extension select is a pin: two flops before use
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_m_r <= 1'b0;
            ext_s_r <= 1'b0;
        end else if (ce_i) begin
            ext_m_r <= extension_driver_select_i;
            ext_s_r <= ext_m_r;
        end
    end

    // ---------------- pattern fetch ----------------
    logic icon_row; // scanning the icon common
    logic [4:0] rr; // glyph scan row, 0..31
    logic [1:0] line;
    logic blank_row;
    logic [6:0] base;
    logic [6:0] pos_eff;
    logic [6:0] cc_addr;
    logic [7:0] code;
    logic user;
    logic [2:0] grow;
    logic [4:0] rom_dots;
    logic [7:0] sel_byte;
    logic [2:0] bidx; // bit of the byte for this column
    logic pix;
    logic blink_dot;
    logic show_cur;
    logic pix_c;
    logic pix_f;

    assign icon_row = (scan_r == 6'h00);
    assign rr = 5'(scan_r - 6'h01);
    assign grow = rr[2:0];

    // line layout by mode
    always_comb begin
        if (nw4) begin
            line = rr[4:3];
            base = {rr[4:3], 5'h00};
            blank_row = 1'b0;
        end else if (two_line_r) begin
            line = {1'b0, rr[4]};
            base = {rr[4], 6'h00};
            blank_row = rr[3];
        end else begin
            line = 2'h0;
            base = 7'h00;
            blank_row = (rr[4:3] != 2'h0);
        end
    end

    // rotated address inside the line's own range
    always_comb begin
        pos_eff = {2'h0, pos_r} + off_r[line];
        if (pos_eff >= len) begin
            pos_eff = pos_eff - len;
        end
        cc_addr = base + pos_eff;
    end

    assign code = cc_ram[cc_addr];
    assign user = (code[7:4] == 4'h0);

    clpf_glyph_rom u_rom (
        .code_i(code),
        .row_i(grow),
        .dots_o(rom_dots)
    );

    // source byte: icon ram, user glyph row or rom row
    always_comb begin
        if (icon_row) begin
            sel_byte = (pos_r < 5'h10) ? ic_ram[pos_r[3:0]] : 8'h00;
        end else if (user) begin
            sel_byte = ug_ram[{code[2:0], grow}];
        end else begin
            sel_byte = {3'h0, rom_dots};
        end
    end

    // leftmost column is the highest pattern bit
    assign bidx = wlast - col_r;
    assign pix = sel_byte[bidx] & ~(blank_row & ~icon_row);

    // bit 7 blinks the whole cell, bit 6 only the leftmost column
    assign blink_dot = be_r & (icon_row | user) &
        (sel_byte[7] | (sel_byte[6] & bidx == wlast));

    // cursor cell, suppressed in the off half of a cursor blink
    assign show_cur = ctrl_r[CLPF_CTRL_CUR] & ~icon_row &
        (cc_addr == ac_r) & (tgt_r == CLPF_TGT_CHAR) &
        ~(ctrl_r[CLPF_CTRL_CBL] & phase_r);
    assign pix_c = ctrl_r[CLPF_CTRL_BW] ? pix ^ show_cur :
        pix | (show_cur & grow == 3'h7);
    assign pix_f = pix_c & ~(blink_dot & phase_r) &
        ctrl_r[CLPF_CTRL_DON];

    // ---------------- refresh sequencer ----------------
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= CLPF_ST_IDLE;
            scan_r <= 6'h00;
            bit_r <= 7'h00;
            col_r <= 3'h0;
            pos_r <= 5'h00;
        end else if (ce_i) begin
            case (st_r)
                CLPF_ST_IDLE: st_r <= CLPF_ST_SHIFT;
                CLPF_ST_SHIFT: begin
                    bit_r <= bit_r + 7'h01;
                    col_r <= (col_r >= wlast) ? 3'h0 : col_r + 3'h1;
                    if (col_r >= wlast) begin
                        pos_r <= pos_r + 5'h01;
                    end
                    if (bit_r >= last_bit) begin
                        st_r <= CLPF_ST_LATCH;
                    end
                end
                CLPF_ST_LATCH: begin
                    bit_r <= 7'h00;
                    col_r <= 3'h0;
                    pos_r <= 5'h00;
                    // >= recovers if the mode shrinks mid-frame
                    scan_r <= (scan_r >= last_com) ? 6'h00 :
                        scan_r + 6'h01;
                    st_r <= CLPF_ST_SHIFT;
                end
                default: st_r <= CLPF_ST_IDLE;
            endcase
        end
    end

    // serial fill of the segment latch and extension stream
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seg_sh_r <= '0;
            ext_d_r <= 1'b0;
            ext_c_r <= 1'b0;
        end else if (ce_i) begin
            ext_c_r <= 1'b0;
            if (st_r == CLPF_ST_SHIFT) begin
                if (bit_r < 7'(CLPF_SEG_N)) begin
                    seg_sh_r <= {pix_f, seg_sh_r[CLPF_SEG_N-1:1]};
                end else if (ext_s_r) begin
                    ext_d_r <= pix_f;
                    ext_c_r <= 1'b1;
                end
            end
        end
    end

    // parallel transfer with the common select
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seg_r <= '0;
            com_r <= '0;
            ext_l_r <= 1'b0;
        end else if (ce_i) begin
            ext_l_r <= (st_r == CLPF_ST_LATCH) & ext_s_r;
            if (st_r == CLPF_ST_LATCH) begin
                seg_r <= seg_sh_r;
                com_r <= '0;
                com_r[scan_r] <= 1'b1;
                if (icon_row) begin
                    // icon common is paired with common 33, or 17 in 1-line mode
                    com_r[multi ? 33 : 17] <= 1'b1;
                end
            end
        end
    end

    // blink phase from frame count, common to all dots
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_r <= 6'h00;
            phase_r <= 1'b0;
        end else if (ce_i && st_r == CLPF_ST_LATCH && scan_r >= last_com) begin
            if (frame_r >= 6'(BLINK_FRAMES - 1)) begin
                frame_r <= 6'h00;
                phase_r <= ~phase_r;
            end else begin
                frame_r <= frame_r + 6'h01;
            end
        end
    end

    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hready_r;
    assign hresp_o = 1'b0;
    assign com_o = com_r;
    assign seg_o = seg_r;
    assign ext_data_o = ext_d_r;
    assign ext_clk_o = ext_c_r;
    assign ext_latch_o = ext_l_r;

    // ---------------- checks ----------------
    a_ac_load: assert property (ce_i && wr_do && ofs_r == CLPF_OFS_ADDR |=>
        ac_r[3:0] == $past(hwdata_i[3:0]) &&
        tgt_r == $past(hwdata_i[9:8])) else $error("counter not loaded");
    a_ac_step_up: assert property (ce_i && wr_do &&
        ofs_r == CLPF_OFS_DATA && tgt_r == CLPF_TGT_ICON &&
        ctrl_r[CLPF_CTRL_INC] |=> ac_r[3:0] == $past(ac_r[3:0]) + 4'h1)
        else $error("counter did not step up");
    a_ac_step_down: assert property (ce_i && rd_do &&
        ofs_r == CLPF_OFS_DATA && tgt_r == CLPF_TGT_CHAR &&
        !ctrl_r[CLPF_CTRL_INC] |=> ac_r == $past(ac_r) - 7'h01)
        else $error("counter did not step down");
    a_ac_readback: assert property (ce_i && rd_do &&
        ofs_r == CLPF_OFS_ADDR |=> hrdata_o[6:0] == $past(ac_r) &&
        hreadyout_o) else $error("counter read wrong");
    // exact compare: cells of unwritten ram pass through as they are
    a_seg_transfer: assert property (ce_i && st_r == CLPF_ST_LATCH |=>
        seg_o === $past(seg_sh_r)) else $error("segment latch not moved");
    a_duty_one: assert property (ce_i && st_r == CLPF_ST_LATCH &&
        !multi && scan_r == 6'h10 |=> scan_r == 6'h00 ##1 scan_r == 6'h00)
        else $error("1-line scan did not wrap");
    a_duty_multi: assert property (ce_i && st_r == CLPF_ST_LATCH &&
        multi && scan_r == 6'h20 |=> scan_r == 6'h00)
        else $error("multi-line scan did not wrap");
    a_icon_pair: assert property (ce_i && st_r == CLPF_ST_LATCH &&
        icon_row |=> com_o[0] && com_o[$past(multi) ? 33 : 17])
        else $error("icon common not paired");
    a_blink_gate: assert property (!be_r |-> !blink_dot)
        else $error("blink while disabled");
    a_ext_quiet: assert property (ce_i && !ext_s_r |=> !ext_clk_o)
        else $error("extension clocked while deselected");
    c_icon_latch: cover property (ce_i && st_r == CLPF_ST_LATCH && icon_row);
    c_data_read: cover property (ce_i && rd_do && ofs_r == CLPF_OFS_DATA);
    c_ext_bit: cover property (ext_clk_o && ext_data_o);
    c_blink_dot: cover property (blink_dot && phase_r);
endmodule // clpf_top

/* File: logic/clpf_pkg.sv */
// constants shared by the character lcd pattern fetch block
package clpf_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] CLPF_OFS_CTRL = 8'h00;
    localparam logic [7:0] CLPF_OFS_FUNC = 8'h04;
    localparam logic [7:0] CLPF_OFS_ADDR = 8'h08;
    localparam logic [7:0] CLPF_OFS_DATA = 8'h0C;
    localparam logic [7:0] CLPF_OFS_SHIFT = 8'h10;
    localparam logic [7:0] CLPF_OFS_STAT = 8'h14;
    // control register fields
    localparam int CLPF_CTRL_FW = 0;
    localparam int CLPF_CTRL_NW = 1;
    localparam int CLPF_CTRL_INC = 2;
    localparam int CLPF_CTRL_CUR = 3;
    localparam int CLPF_CTRL_CBL = 4;
    localparam int CLPF_CTRL_BW = 5;
    localparam int CLPF_CTRL_DON = 6;
    localparam int CLPF_CTRL_SEN = 8;
    localparam logic [11:0] CLPF_CTRL_RST = 12'h044;
    // function set fields
    localparam int CLPF_FUNC_N = 0;
    localparam int CLPF_FUNC_BE = 1;
    localparam int CLPF_FUNC_EXT = 2;
    // address set: target field position
    localparam int CLPF_ADDR_TGT = 8;
    // shift command fields
    localparam int CLPF_SHIFT_RIGHT = 0;
    localparam int CLPF_SHIFT_GO = 1;
    // address counter wrap masks per ram
    localparam logic [6:0] CLPF_MASK_CHAR = 7'h7F;
    localparam logic [6:0] CLPF_MASK_USER = 7'h3F;
    localparam logic [6:0] CLPF_MASK_ICON = 7'h0F;
    // line lengths in char_code_ram addresses
    localparam logic [6:0] CLPF_LEN_4L = 7'h14;
    localparam logic [6:0] CLPF_LEN_2L = 7'h28;
    localparam logic [6:0] CLPF_LEN_1L = 7'h50;
    // panel geometry and scan counts
    localparam int CLPF_SEG_N = 60;
    localparam int CLPF_COM_N = 34;
    localparam logic [5:0] CLPF_LAST_1L = 6'h10;
    localparam logic [5:0] CLPF_LAST_ML = 6'h20;
    localparam int CLPF_EXT_SEGS = 40;
    localparam int CLPF_BLINK_FRAMES = 16;
    // ram target selector
    typedef enum logic [1:0] {
        CLPF_TGT_CHAR = 2'h0,
        CLPF_TGT_USER = 2'h1,
        CLPF_TGT_ICON = 2'h2
    } clpf_tgt_t;
    // refresh sequencer states
    typedef enum logic [2:0] {
        CLPF_ST_IDLE = 3'b001,
        CLPF_ST_SHIFT = 3'b010,
        CLPF_ST_LATCH = 3'b100
    } clpf_state_t;
endpackage

/* File: logic/clpf_glyph_rom.sv */
// fixed glyph rom: one 5-dot row per character code and row
`timescale 1ns/100ps
module clpf_glyph_rom (
    input wire logic [7:0] code_i,
    input wire logic [2:0] row_i,
    output logic [4:0] dots_o
);
    // 240 glyphs, codes 10H-FFH, 5 dots by 8 rows
    // glyph art is a generated stand-in; geometry is exact
    always_comb begin
        if (row_i == 3'h7 || code_i[7:4] == 4'h0) begin
            dots_o = 5'h00; // descender row and user codes blank
        end else begin
            dots_o = code_i[4:0] ^ {row_i, row_i[1:0]};
        end
    end
endmodule // clpf_glyph_rom

/* File: bench/clpf_panel_model.sv */
// panel-side model: measures scan frames and the extension stream
`timescale 1ns/100ps
module clpf_panel_model (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [33:0] com_i,
    input wire logic ext_clk_i,
    input wire logic ext_latch_i,
    output int frames_o,
    output int frame_len_o,
    output logic [33:0] icon_com_o,
    output int ext_bits_o
);
    logic [33:0] com_r; // common seen last cycle
    int lines_r; // lines since the last icon common
    int ext_r; // extension clocks on this line
    // a changed common means a line latch; the icon common ends a frame
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            com_r <= '0;
            lines_r <= 0;
            frames_o <= 0;
            frame_len_o <= 0;
            icon_com_o <= '0;
        end else if (com_i != com_r) begin
            com_r <= com_i;
            lines_r <= com_i[0] ? 1 : lines_r + 1;
            if (com_i[0]) begin
                frames_o <= frames_o + 1;
                frame_len_o <= lines_r;
                icon_com_o <= com_i;
            end
        end
    end
    // extension clocks counted per line, kept at the latch pulse
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_r <= 0;
            ext_bits_o <= 0;
        end else if (ext_latch_i) begin
            ext_r <= 0;
            ext_bits_o <= ext_r;
        end else if (ext_clk_i) begin
            ext_r <= ext_r + 1;
        end
    end
endmodule // clpf_panel_model

/* File: bench/char_lcd_pattern_fetch_tb.sv */
// self-checking bench for the character lcd pattern fetch block
`timescale 1ns/100ps
module char_lcd_pattern_fetch_tb;
    import clpf_pkg::*;
    logic clock_i = 1'b0; // 25 MHz bench clock
    logic rstn_i = 1'b0; // active-low reset
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic ext_sel = 1'b0; // extension driver fitted
    logic [31:0] hrdata;
    logic hready, hresp, ext_data, ext_clk, ext_latch;
    logic [33:0] com, icon_com;
    logic [59:0] seg;
    int frames, frame_len, ext_bits;
    logic [63:0] exp_q[$]; // expected read: mask above, value below
    logic [63:0] e;
    logic rd_dp = 1'b0; // a read data phase is pending
    logic [7:0] b0, b1; // random ram bytes
    int err_total = 0;
    int tests_run = 0;
    always #20 clock_i = ~clock_i;
    clpf_top clpf_top_inst (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .extension_driver_select_i(ext_sel), .com_o(com), .seg_o(seg),
        .ext_data_o(ext_data), .ext_clk_o(ext_clk), .ext_latch_o(ext_latch));
    clpf_panel_model clpf_panel_model_inst (.clock_i(clock_i),
        .rstn_i(rstn_i), .com_i(com), .ext_clk_i(ext_clk),
        .ext_latch_i(ext_latch), .frames_o(frames), .frame_len_o(frame_len),
        .icon_com_o(icon_com), .ext_bits_o(ext_bits));
    task automatic check_v(input logic [33:0] ex, input logic [33:0] got);
        tests_run++;
        if (got !== ex) begin
            err_total++;
            $display("[ERR] value exp %0h got %0h", ex, got);
        end
    endtask
    task automatic check_n(input int ex, input int got);
        tests_run++;
        if (got != ex) begin
            err_total++;
            $display("[ERR] count exp %0d got %0d", ex, got);
        end
    endtask
    // one single word transfer; address held until hready, then data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clock_i);
        while (hready !== 1'b1) @(posedge clock_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock_i);
        while (hready !== 1'b1) @(posedge clock_i);
        hsel <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        exp_q.push_back({m, x});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_frames(input int n);
        int f0;
        f0 = frames;
        while (frames < f0 + n) @(posedge clock_i);
    endtask
    // read data is judged at the edge that ends its data phase
    always @(posedge clock_i) begin
        if (rd_dp && hready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check_v({2'h0, e[31:0]}, {2'h0, hrdata & e[63:32]});
            rd_dp = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hready === 1'b1) rd_dp = 1'b1;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #(40 * 60000);
        err_total++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h8D23));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        repeat (4) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(CLPF_OFS_CTRL, 32'h44, 32'hFFF);
        rd(8'h18, 32'h0, 32'hFFFFFFFF);
        wr(CLPF_OFS_FUNC, 32'h2);
        rd(CLPF_OFS_FUNC, 32'h0, 32'h3);
        wr(CLPF_OFS_FUNC, 32'h6);
        rd(CLPF_OFS_FUNC, 32'h2, 32'h3);
        wr(CLPF_OFS_ADDR, 32'h13);
        rd(CLPF_OFS_ADDR, 32'h13, 32'h37F);
        wr(CLPF_OFS_DATA, {24'h0, b0});
        wr(CLPF_OFS_DATA, {24'h0, b1});
        rd(CLPF_OFS_ADDR, 32'h15, 32'h37F);
        wr(CLPF_OFS_ADDR, 32'h13);
        rd(CLPF_OFS_DATA, {24'h0, b0}, 32'hFF);
        rd(CLPF_OFS_DATA, {24'h0, b1}, 32'hFF);
        rd(CLPF_OFS_ADDR, 32'h15, 32'h37F);
        // decrement must wrap inside the user and icon rams' own widths
        wr(CLPF_OFS_CTRL, 32'h40);
        wr(CLPF_OFS_ADDR, 32'h100);
        wr(CLPF_OFS_DATA, {24'h0, b0});
        rd(CLPF_OFS_ADDR, 32'h13F, 32'h37F);
        wr(CLPF_OFS_ADDR, 32'h200);
        wr(CLPF_OFS_DATA, {24'h0, b1});
        rd(CLPF_OFS_ADDR, 32'h20F, 32'h37F);
        // data read steps the char counter down, icon write wraps up
        wr(CLPF_OFS_ADDR, 32'h14);
        rd(CLPF_OFS_DATA, {24'h0, b1}, 32'hFF);
        rd(CLPF_OFS_ADDR, 32'h13, 32'h37F);
        wr(CLPF_OFS_CTRL, 32'h44);
        wr(CLPF_OFS_ADDR, 32'h20F);
        wr(CLPF_OFS_DATA, {24'h0, b0});
        rd(CLPF_OFS_ADDR, 32'h200, 32'h37F);
        // scan length and icon common pairing per line mode
        wait_frames(2);
        check_n(17, frame_len);
        check_v(34'h000020001, icon_com);
        // icon line stands now; first cell shows D4 leftmost, phase still low
        check_v({29'h0, b1[0], b1[1], b1[2], b1[3], b1[4]},
            {29'h0, seg[4:0]});
        wr(CLPF_OFS_FUNC, 32'h1);
        wait_frames(2);
        check_n(33, frame_len);
        check_v(34'h200000001, icon_com);
        ext_sel <= 1'b1;
        wr(CLPF_OFS_CTRL, 32'h42);
        wait_frames(2);
        check_n(33, frame_len);
        check_n(40, ext_bits);
        rd(CLPF_OFS_STAT, 32'h100, 32'h100);
        end_sim();
    end
endmodule // char_lcd_pattern_fetch_tb
